/* File: src/lcd_reset_pkg.sv */
package lcd_reset_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMD_ADDR    = 8'h00; // instruction entry: write issues
  localparam logic [7:0] STATUS_ADDR = 8'h04; // init state readback
  localparam logic [7:0] PORT_ADDR   = 8'h08; // general-purpose port output view
  localparam logic [7:0] ADDR_ADDR   = 8'h0c; // address counter and contrast

  // ---------------------------------------------------------------------------
  // instruction word layout: opcode in [31:28], argument in [27:0]
  // ---------------------------------------------------------------------------
  localparam int OPC_LSB      = 28;
  localparam int OC_BIT       = 0;  // osc_source_select in technique argument
  localparam int SHARED_BIT   = 1;  // shared pin role: 1 = common
  localparam int DISP_ON_BIT  = 0;  // display on/off argument
  localparam int KEYSCAN_BIT  = 3;  // port state: 1 selects key scan on shared pins

  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_TECHNIQUE = 4'h1,
    OP_CHAR_WR   = 4'h2,
    OP_AUX_WR    = 4'h3,
    OP_GLYPH_WR  = 4'h4,
    OP_SET_ADDR  = 4'h5,
    OP_CONTRAST  = 4'h6,
    OP_DISPLAY   = 4'h7,
    OP_PORT      = 4'h8
  } opcode_t;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [6:0] ADDR_RST     = 7'h00;
  localparam logic [3:0] CONTRAST_RST = 4'h0;
  localparam logic [2:0] GP_RST       = 3'h0;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

endpackage : lcd_reset_pkg

/* File: src/reset_sync.sv */
`timescale 1ns/10ps
// asserts reset at once, releases it two clocks after supply recovers
module reset_sync (
  // clock and raw reset
  input  wire logic sys_clk,
  input  wire logic rawRstn,
  // synchronised reset
  output logic      syncRstn
);

  logic stage1_q;  // first stage, read only by the second
  logic stage2_q;  // second stage drives the output

  // ---------------------------------------------------------------------------
  // release synchroniser
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rawRstn)
  begin
    if (!rawRstn)
    begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end
    else
    begin
      stage1_q <= 1'b1;
      stage2_q <= stage1_q;
    end
  end

  assign syncRstn = stage2_q;

endmodule : reset_sync

/* File: src/sync2.sv */
`timescale 1ns/10ps
// two flip-flop synchroniser for pin levels
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // async level in, synced level out
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_q;  // first stage
  logic [W-1:0] hold_q;  // second stage

  // ---------------------------------------------------------------------------
  // two stages
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      hold_q <= '0;
    end
    else
    begin
      meta_q <= asyncIn;
      hold_q <= meta_q;
    end
  end

  assign syncOut = hold_q;

endmodule : sync2

/* File: src/lcd_reset_ctrl.sv */
`timescale 1ns/10ps
// reset and initialisation state of the lcd driver, AXI4-Lite controlled
module lcd_reset_ctrl (
  // clock and supply-drop reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // axi write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi read address
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // axi read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // pins
  input  wire logic        displayInhibitN,  // display_inhibit_n pin
  input  wire logic        keyReadReq,       // key scan core wants a key read
  // driven state
  output logic             displayOn,
  output logic             latchLoad,        // pulse: latch takes ram/rom data
  output logic             keyScanEn,
  output logic             keyDataClear,
  output logic             gpLockLow,
  output logic [2:0]       gpOutputs,
  output logic             sharedComMode,    // shared_seg_com_pin role
  output logic             sharedScanMode,   // shared key scan/port pins role
  output logic             oscRun,
  output logic             oscSource,        // osc_source_select
  output logic             oscPinOe,         // low = high impedance
  output logic             execEnable,
  output logic             contrastEn,
  output logic [3:0]       contrastLevel,
  output logic [6:0]       addrCounter,
  output logic             serialIdle,
  output logic             keyRequestOut,
  output logic             keyRequestOe
);
  import lcd_reset_pkg::*;

  // ---------------------------------------------------------------------------
  // reset and pin synchronisation
  // ---------------------------------------------------------------------------
  logic iRstn;    // internal reset, async assert, sync release
  logic inhSync;  // synchronised display_inhibit_n

  reset_sync uRst (
    .sys_clk  (sys_clk),
    .rawRstn  (rstn),
    .syncRstn (iRstn)
  );

  sync2 #(.W(1)) uInh (
    .sys_clk (sys_clk),
    .rstn    (iRstn),
    .asyncIn (displayInhibitN),
    .syncOut (inhSync)
  );

  // ---------------------------------------------------------------------------
  // axi slave state
  // ---------------------------------------------------------------------------
  logic        awHeld_q, awHeld_d;   // write address taken
  logic        wHeld_q,  wHeld_d;    // write data taken
  logic [7:0]  awAddr_q, awAddr_d;   // captured write address
  logic [31:0] wData_q,  wData_d;    // captured write data
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q,  bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  rresp_q,  rresp_d;
  logic [31:0] rdata_q,  rdata_d;
  logic        doWrite;              // both halves held, issue now
  logic        cmdValid;             // any write to command register; partial strobes give zero data

  // returns the opcode field of an instruction word
  function automatic opcode_t opOf(input logic [31:0] w);
    opOf = opcode_t'(w[OPC_LSB +: 4]);
  endfunction : opOf

  // ---------------------------------------------------------------------------
  // init state
  // ---------------------------------------------------------------------------
  logic       techDone_q, techDone_d;   // technique executed since reset
  logic       portDone_q, portDone_d;   // port state after technique
  logic       dispOn_q,   dispOn_d;
  logic       latch_q,    latch_d;
  logic       comMode_q,  comMode_d;
  logic       scanMode_q, scanMode_d;
  logic       oscSel_q,   oscSel_d;
  logic       contEn_q,   contEn_d;
  logic [3:0] cont_q,     cont_d;
  logic [6:0] addr_q,     addr_d;
  logic [2:0] gp_q,       gp_d;
  logic       keyReq_q,   keyReq_d;
  opcode_t    op;
  logic [27:0] arg;

  // ---------------------------------------------------------------------------
  // axi next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    awHeld_d = awHeld_q;
    wHeld_d  = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d  = wData_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    doWrite  = awHeld_q && wHeld_q && !bvalid_q;
    cmdValid = 1'b0;
    // address and data accepted in either order
    if (awvalid && !awHeld_q)
    begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && !wHeld_q)
    begin
      wHeld_d = 1'b1;
      wData_d = (wstrb == 4'hf) ? wdata : 32'h0000_0000;
    end
    // issue and respond
    if (doWrite)
    begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bvalid_d = 1'b1;
      if (awAddr_q[7:2] == CMD_ADDR[7:2])
      begin
        cmdValid = 1'b1;
        bresp_d  = RESP_OKAY;
      end
      else
        bresp_d = RESP_SLVERR;   // read-only or unmapped
    end
    else if (bvalid_q && bready)
      bvalid_d = 1'b0;
    // reads
    if (arvalid && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (araddr[7:2])
        STATUS_ADDR[7:2]: rdata_d = {24'h0, dispOn_q, keyScanEn, gpLockLow, oscRun,
                                     oscSel_q, comMode_q, scanMode_q, contEn_q};
        PORT_ADDR[7:2]:   rdata_d = {29'h0, gp_q};
        ADDR_ADDR[7:2]:   rdata_d = {21'h0, cont_q, addr_q};
        CMD_ADDR[7:2]:    rdata_d = 32'h0000_0000;
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && rready)
      rvalid_d = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge iRstn)
  begin
    if (!iRstn)
    begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q  <= 32'h0000_0000;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end
    else
    begin
      awHeld_q <= awHeld_d;
      wHeld_q  <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q  <= wData_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // instruction execution
  // ---------------------------------------------------------------------------
  always_comb
  begin
    techDone_d = techDone_q;
    portDone_d = portDone_q;
    dispOn_d   = dispOn_q;
    latch_d    = 1'b0;
    comMode_d  = comMode_q;
    scanMode_d = scanMode_q;
    oscSel_d   = oscSel_q;
    contEn_d   = contEn_q;
    cont_d     = cont_q;
    addr_d     = addr_q;
    gp_d       = gp_q;
    op         = opOf(wData_q);
    arg        = wData_q[27:0];
    if (cmdValid)
    begin
      case (op)
        OP_TECHNIQUE:
        begin
          techDone_d = 1'b1;
          oscSel_d   = arg[OC_BIT];
          comMode_d  = arg[SHARED_BIT];
        end
        OP_PORT:
          if (techDone_q)
          begin
            portDone_d = 1'b1;
            gp_d       = arg[2:0];
            scanMode_d = arg[KEYSCAN_BIT];
          end
        OP_SET_ADDR:
          if (techDone_q)
            addr_d = arg[6:0];
        OP_CONTRAST:
          if (techDone_q)
          begin
            contEn_d = 1'b1;
            cont_d   = arg[3:0];
          end
        OP_DISPLAY:
          if (techDone_q)
          begin
            dispOn_d = arg[DISP_ON_BIT];
            latch_d  = 1'b1;                 // on or off both reload the latch
          end
        default: ;
      endcase
    end
    // inhibit pin forces display off
    if (!inhSync)
      dispOn_d = 1'b0;
    // key request only once scanning is allowed
    keyReq_d = portDone_d && keyReadReq && !cmdValid;
  end

  always_ff @(posedge sys_clk or negedge iRstn)
  begin
    if (!iRstn)
    begin
      techDone_q <= 1'b0;
      portDone_q <= 1'b0;
      dispOn_q   <= 1'b0;
      latch_q    <= 1'b0;
      comMode_q  <= 1'b0;
      scanMode_q <= 1'b0;
      oscSel_q   <= 1'b0;
      contEn_q   <= 1'b0;
      cont_q     <= CONTRAST_RST;
      addr_q     <= ADDR_RST;
      gp_q       <= GP_RST;
      keyReq_q   <= 1'b0;
    end
    else
    begin
      techDone_q <= techDone_d;
      portDone_q <= portDone_d;
      dispOn_q   <= dispOn_d;
      latch_q    <= latch_d;
      comMode_q  <= comMode_d;
      scanMode_q <= scanMode_d;
      oscSel_q   <= oscSel_d;
      contEn_q   <= contEn_d;
      cont_q     <= cont_d;
      addr_q     <= addr_d;
      gp_q       <= gp_d;
      keyReq_q   <= keyReq_d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all from flip-flops except keyRequestOut, tied low
  // ---------------------------------------------------------------------------
  assign awready       = !awHeld_q;
  assign wready        = !wHeld_q;
  assign bvalid        = bvalid_q;
  assign bresp         = bresp_q;
  assign arready       = !rvalid_q;
  assign rvalid        = rvalid_q;
  assign rresp         = rresp_q;
  assign rdata         = rdata_q;
  assign displayOn     = dispOn_q;
  assign latchLoad     = latch_q;
  assign keyScanEn     = portDone_q;
  assign keyDataClear  = !portDone_q;
  assign gpLockLow     = !portDone_q;
  assign gpOutputs     = gp_q;
  assign sharedComMode = comMode_q;
  assign sharedScanMode = scanMode_q;
  assign oscRun        = techDone_q;
  assign oscSource     = oscSel_q;
  assign oscPinOe      = techDone_q & ~oscSel_q;
  assign execEnable    = techDone_q;
  assign contrastEn    = contEn_q;
  assign contrastLevel = cont_q;
  assign addrCounter   = addr_q;
  assign serialIdle    = !awHeld_q && !wHeld_q;
  assign keyRequestOut = 1'b0;
  assign keyRequestOe  = keyReq_q;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!iRstn);

  a_disp_needs_tech: assert property (displayOn |-> execEnable)
    else $error("display on before technique");
  a_gp_lock_low: assert property (gpLockLow |-> gpOutputs == 3'h0)
    else $error("gp outputs not low while locked");
  a_scan_after_port: assert property ($rose(keyScanEn) |-> $past(execEnable))
    else $error("key scan enabled without technique");
  a_key_req_hold: assert property (!keyScanEn |-> !keyRequestOe)
    else $error("key request driven before enable");
  a_osc_src: assert property (execEnable && !oscSource |-> oscPinOe)
    else $error("rc oscillator pin not driven");
  a_latch_load: assert property (latchLoad |-> $past(cmdValid) && $past(op) == OP_DISPLAY)
    else $error("latch load without display command");
  a_contrast_lock: assert property (contrastEn |-> execEnable)
    else $error("contrast before technique");
  a_addr_stable: assert property (!(cmdValid && op == OP_SET_ADDR) |=> $stable(addrCounter))
    else $error("address changed without command");

  c_tech: cover property ($rose(execEnable));
  c_disp: cover property ($rose(displayOn));
  c_scan: cover property ($rose(keyScanEn));

endmodule : lcd_reset_ctrl

/* File: testbench/host_axi_model.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// host side: axi4-lite master that issues driver instructions
// ---------------------------------------------------------------
module host_axi_model (
  // clock
  input  wire logic        sys_clk,
  // write channels
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // read channels
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  int respDelay = 0;  // cycles before bready rises, for a slow host

  // idle levels at time zero
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic awDone;
    logic wDone;
    awDone = 0;
    wDone  = 0;
    @(posedge sys_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    while (!(awDone && wDone))
    begin
      @(posedge sys_clk);
      // released lines show the inverse, not the last value
      if (!awDone && awready === 1'b1)
      begin
        awDone = 1;
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (!wDone && wready === 1'b1)
      begin
        wDone = 1;
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end
    repeat (respDelay) @(posedge sys_clk);
    bready <= 1'b1;
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  // one read: rready held until rvalid is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr  <= ~a;
    while (rvalid !== 1'b1) @(posedge sys_clk);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : host_axi_model

/* File: testbench/lcd_reset_ctrl_tb.sv */
`timescale 1ns/10ps
module lcd_reset_ctrl_tb;
  import lcd_reset_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        sys_clk, rstn, displayInhibitN, keyReadReq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, contrastLevel;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        displayOn, latchLoad, keyScanEn, keyDataClear, gpLockLow;
  logic [2:0]  gpOutputs;
  logic        sharedComMode, sharedScanMode, oscRun, oscSource, oscPinOe;
  logic        execEnable, contrastEn, serialIdle, keyRequestOut, keyRequestOe;
  logic [6:0]  addrCounter;
  int          badCount = 0;  // mismatches
  int          nChecks  = 0;  // comparisons made
  int          latchCnt = 0;  // latch load pulses seen
  logic [31:0] d;
  logic [1:0]  r;
  typedef struct { logic [31:0] cmd; logic [7:0] ra; logic [31:0] exp; } row_t;
  row_t        rows[9];       // instruction, readback address, expected word

  lcd_reset_ctrl i_dut (.*);
  host_axi_model i_host (.*);

  // 250 MHz clock
  initial
  begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end

  // count latch pulses
  always @(posedge sys_clk) if (latchLoad === 1'b1) latchCnt++;

  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check_val

  // every driven-state output except latchLoad and oscSource held in its reset state
  task automatic chk_reset;
    check_val({displayOn, keyScanEn, keyDataClear, gpLockLow, gpOutputs, sharedComMode,
      sharedScanMode, oscRun, oscPinOe, execEnable, contrastEn, contrastLevel, addrCounter,
      serialIdle, keyRequestOut, keyRequestOe},
      {4'b0011, GP_RST, 6'h00, CONTRAST_RST, ADDR_RST, 3'b100});
  endtask : chk_reset

  task automatic cmd(input opcode_t op, input logic [27:0] arg);
    i_host.wr(CMD_ADDR, {op, arg}, r);
  endtask : cmd

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    $display("BAD t=%0t watchdog expired", $time);
    report_and_stop;
  end

  // main sequence
  initial
  begin
    rstn = 0;
    displayInhibitN = 1;
    keyReadReq = 0;
    // setup order: technique first, display on after ram, address, contrast
    rows = '{'{{OP_TECHNIQUE, 28'h3}, STATUS_ADDR, 32'h3c},
             '{{OP_CHAR_WR, 28'h0}, STATUS_ADDR, 32'h3c},
             '{{OP_AUX_WR, 28'h0}, STATUS_ADDR, 32'h3c},
             '{{OP_GLYPH_WR, 28'h0}, STATUS_ADDR, 32'h3c},
             '{{OP_SET_ADDR, 28'h55}, ADDR_ADDR, 32'h55},
             '{{OP_CONTRAST, 28'h9}, ADDR_ADDR, 32'h4d5},
             '{{OP_DISPLAY, 28'h1}, STATUS_ADDR, 32'hbd},
             '{{OP_PORT, 28'hd}, STATUS_ADDR, 32'hdf},
             '{{OP_NOP, 28'h0}, PORT_ADDR, 32'h5}};
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk_reset;
    // instructions before technique change nothing
    keyReadReq <= 1'b1;
    cmd(OP_PORT, 28'hd);
    cmd(OP_DISPLAY, 28'h1);
    cmd(OP_SET_ADDR, 28'h11);
    cmd(OP_CONTRAST, 28'h3);
    chk_reset;
    $display("test early instructions done");
    foreach (rows[i])
    begin
      i_host.wr(CMD_ADDR, rows[i].cmd, r);
      check_val(r, RESP_OKAY);
      i_host.rd(rows[i].ra, d, r);
      check_val(d, rows[i].exp);
    end
    $display("test setup rows done");
    check_val({gpOutputs, keyDataClear, keyScanEn, gpLockLow}, 6'b101010);
    check_val(oscPinOe, 1'b0);
    for (int k = 0; k < 8 && keyRequestOe !== 1'b1; k++) @(posedge sys_clk);
    check_val(keyRequestOe, 1'b1);
    d = latchCnt;
    cmd(OP_DISPLAY, 28'h0);
    cmd(OP_DISPLAY, 28'h1);
    // let the pulse counter see the last pulse before comparing
    @(posedge sys_clk);
    check_val(latchCnt - d, 32'h2);
    // power-down style display off by the inhibit pin
    displayInhibitN <= 1'b0;
    for (int k = 0; k < 8 && displayOn !== 1'b0; k++) @(posedge sys_clk);
    check_val(displayOn, 1'b0);
    displayInhibitN <= 1'b1;
    // unmapped accesses
    i_host.wr(8'h10, 32'h0, r);
    check_val(r, RESP_SLVERR);
    i_host.rd(8'h30, d, r);
    check_val(r, RESP_SLVERR);
    check_val(d, 32'h0);
    // slow host, top address
    i_host.respDelay = 3;
    cmd(OP_SET_ADDR, 28'h7f);
    i_host.respDelay = 0;
    i_host.rd(ADDR_ADDR, d, r);
    check_val(d, 32'h4ff);
    $display("test hand cases done");
    // supply drop in mid-run: takes effect before the next edge
    @(posedge sys_clk) rstn <= 1'b0;
    #1;
    chk_reset;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // port state before technique is not the ordered pair
    cmd(OP_PORT, 28'h2);
    cmd(OP_TECHNIQUE, 28'h0);
    i_host.rd(STATUS_ADDR, d, r);
    check_val(d, 32'h30);
    check_val(oscPinOe, 1'b1);
    cmd(OP_PORT, 28'h2);
    i_host.rd(STATUS_ADDR, d, r);
    check_val(d, 32'h50);
    i_host.rd(PORT_ADDR, d, r);
    check_val(d, 32'h2);
    $display("test second reset done");
    report_and_stop;
  end
endmodule : lcd_reset_ctrl_tb
